// ---- design/ssd_decoder.sv ----
// sensor state decoder: scan result capture, programmable state machine,
// event routing outputs and flags behind a plain register port
// assumes scan strobes come from sequencer logic on clk_i
// Functional notes
// - The decoder is a software-programmed state machine of up to 16 states.
// - Its input is a vector of up to four sensor bits.
// - A channel result enters the sensor vector only if its decode enable is set.
// - The vector is evaluated once after the scan completes, never mid-scan.
// - Each state has two descriptors matching when unmasked bits equal the compare.
// - A match moves to the descriptor's next state and applies its event action.
// - A match sets the decoder flag when the descriptor asks for it.
// - With chaining on in the first descriptor and neither descriptor matching, the following descriptor pair is evaluated.
// - The decoder runs only between a start and a stop command.
// - In count mode one event output is a count pulse, another the direction.
// - Scan result bits are offered as event outputs to other logic.
// - The direction settles before its count pulse is raised.
// - Optionally leaving state x sets channel flag x.
`timescale 1ns/10ps
`include "ssd_defs.svh"
module ssd_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ssd_pkg::ssd_addr_t addr_i,
    input wire ssd_pkg::ssd_data_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output ssd_pkg::ssd_data_t rdata_o,
    input wire logic scan_valid_i,
    input wire logic [3:0] scan_ch_i,
    input wire logic scan_res_i,
    input wire logic scan_done_i,
    output logic [`SSD_NEVT-1:0] evt_o,
    output logic [`SSD_NCH-1:0] scan_result_reg_evt_o
);
    import ssd_pkg::*;

    function automatic logic desc_match(input ssd_desc_t d, input logic [3:0] s);
        logic [3:0] cmp;
        logic [3:0] msk;
        cmp = d[`SSD_D_CMP +: 4];
        msk = d[`SSD_D_MASK +: 4];
        return ((s ^ cmp) & ~msk) == 4'h0;
    endfunction

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ssd_data_t rdata_q;
    logic run_q;
    logic trirq_q;
    logic cntmode_q;
    logic [3:0] cur_q;
    logic [3:0] sensor_q;
    logic [`SSD_NCH-1:0] scan_result_reg_q;
    logic [`SSD_NCH-1:0] decen_q;
    logic [`SSD_NCH-1:0] chflag_q;
    logic decflag_q;
    logic [`SSD_NEVT-1:0] evt_q;
    logic pend_q;
    ssd_eval_t st_q;
    logic [3:0] pair_q;
    ssd_desc_t a_q;
    ssd_desc_t mem_rd;
    ssd_didx_t mem_ra;
    ssd_desc_t win;
    logic a_hit;
    logic b_hit;
    logic apply;
    logic wr_ctrl;
    logic wr_state;
    logic wr_flag;
    logic [3:0] win_next;
    logic [2:0] win_act;

    assign wr_ctrl = wr_i && addr_i == `SSD_CTRL_OFF;
    assign wr_state = wr_i && addr_i == `SSD_STATE_OFF;
    assign wr_flag = wr_i && addr_i == `SSD_FLAG_OFF;

    // descriptor words: index = {state, second}
    ssd_desc_mem u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_i && addr_i[`SSD_DESC_SEL_BIT]),
        .waddr_i(addr_i[6:2]),
        .wdata_i(wdata_i[`SSD_DESC_W-1:0]),
        .raddr_i(mem_ra),
        .rdata_o(mem_rd)
    );

    assign mem_ra = {pair_q, st_q == SSD_CHKA};
    assign a_hit = desc_match(a_q, sensor_q);
    assign b_hit = desc_match(mem_rd, sensor_q);
    assign apply = st_q == SSD_CHKB && run_q && (a_hit || b_hit);
    assign win = a_hit ? a_q : mem_rd;
    assign win_next = win[`SSD_D_NEXT +: 4];
    assign win_act = win[`SSD_D_ACT +: 3];

    // control register and run state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trirq_q <= 1'b0;
            cntmode_q <= 1'b0;
        end else if (wr_ctrl) begin
            trirq_q <= wdata_i[`SSD_CTRL_TRIRQ];
            cntmode_q <= wdata_i[`SSD_CTRL_CNTMODE];
        end
    end

    // stop wins over start in one write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
        end else if (wr_ctrl && wdata_i[`SSD_CTRL_STOP]) begin
            run_q <= 1'b0;
        end else if (wr_ctrl && wdata_i[`SSD_CTRL_START]) begin
            run_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            decen_q <= '0;
        end else if (wr_i && addr_i == `SSD_DECEN_OFF) begin
            decen_q <= wdata_i[`SSD_NCH-1:0];
        end
    end

    // scan capture
    for (genvar g = 0; g < `SSD_NCH; g++) begin : g_scan_result_reg
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                scan_result_reg_q[g] <= 1'b0;
            end else if (scan_valid_i && scan_ch_i == 4'(g)) begin
                scan_result_reg_q[g] <= scan_res_i;
            end
        end
    end

    a_scan_result_reg_evt: assert property (
        scan_valid_i |=> scan_result_reg_evt_o[$past(scan_ch_i)] == $past(scan_res_i)
    ) else $error("scan result bit not routed to event output");

    // enabled channels shift into the sensor vector, others leave it alone
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sensor_q <= 4'h0;
        end else if (scan_valid_i && decen_q[scan_ch_i]) begin
            sensor_q <= {sensor_q[2:0], scan_res_i};
        end
    end

    a_sensor_hold: assert property (
        !(scan_valid_i && decen_q[scan_ch_i]) |=> $stable(sensor_q)
    ) else $error("sensor vector changed without an enabled channel");

    // evaluation sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= SSD_IDLE;
            pair_q <= 4'h0;
            a_q <= '0;
        end else if (!run_q) begin
            st_q <= SSD_IDLE;
        end else begin
            unique case (st_q)
                SSD_IDLE: begin
                    if (scan_done_i) begin
                        st_q <= SSD_RDA;
                        pair_q <= cur_q;
                    end
                end
                SSD_RDA: begin
                    st_q <= SSD_CHKA;
                end
                SSD_CHKA: begin
                    a_q <= mem_rd;
                    st_q <= SSD_CHKB;
                end
                SSD_CHKB: begin
                    if (!a_hit && !b_hit && a_q[`SSD_D_CHAIN]
                        && pair_q != `SSD_LAST_STATE) begin
                        pair_q <= pair_q + 4'h1;
                        st_q <= SSD_RDA;
                    end else begin
                        st_q <= SSD_IDLE;
                    end
                end
            endcase
        end
    end

    a_eval_start: assert property (
        st_q == SSD_IDLE && run_q && !(wr_ctrl && wdata_i[`SSD_CTRL_STOP])
        && scan_done_i |=> st_q == SSD_RDA ##2 st_q == SSD_CHKB
    ) else $error("evaluation did not follow scan completion");

    a_idle_wait: assert property (
        st_q == SSD_IDLE && !scan_done_i |=> st_q == SSD_IDLE
    ) else $error("evaluation started without scan completion");

    a_run_gate: assert property (
        !run_q |=> st_q == SSD_IDLE
    ) else $error("decoder evaluating while stopped");

    a_chain_step: assert property (
        st_q == SSD_CHKB && run_q && !a_hit && !b_hit && a_q[`SSD_D_CHAIN]
        && pair_q != `SSD_LAST_STATE && !(wr_ctrl && wdata_i[`SSD_CTRL_STOP])
        |=> st_q == SSD_RDA && pair_q == $past(pair_q) + 4'h1
    ) else $error("chained descriptor pair not evaluated");

    // current state: software write wins over a transition
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_q <= 4'h0;
        end else if (wr_state) begin
            cur_q <= wdata_i[3:0];
        end else if (apply) begin
            cur_q <= win_next;
        end
    end

    a_match_next: assert property (
        apply && !wr_state |=> cur_q == $past(win_next)
    ) else $error("state not moved to descriptor next state");

    a_prio_first: assert property (
        apply && a_hit && !wr_state |=> cur_q == $past(a_q[`SSD_D_NEXT +: 4])
    ) else $error("second descriptor won over a matching first");

    // event routing outputs; count mode sets direction a cycle before pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_q <= '0;
            pend_q <= 1'b0;
        end else if (apply && cntmode_q) begin
            evt_q <= {win_act[2], win_act[1], 1'b0};
            pend_q <= win_act[0];
        end else if (apply) begin
            evt_q <= win_act;
            pend_q <= 1'b0;
        end else if (cntmode_q) begin
            evt_q[0] <= pend_q;
            pend_q <= 1'b0;
        end
    end

    a_dir_first: assert property (
        cntmode_q && $rose(evt_q[0]) |-> $stable(evt_q[1]) && $past(apply, 2)
    ) else $error("count pulse raised with direction changing");

    a_cnt_pulse: assert property (
        cntmode_q && evt_q[0] |=> !evt_q[0]
    ) else $error("count pulse longer than one cycle");

    a_cnt_follow: assert property (
        apply && cntmode_q && win_act[0] |=> !evt_o[0] ##1 evt_o[0]
    ) else $error("count pulse missing after a counting match");

    // flags: write one to clear, a set in the same cycle wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            decflag_q <= 1'b0;
        end else begin
            decflag_q <= (decflag_q && !(wr_flag && wdata_i[`SSD_FLAG_DEC]))
                || (apply && win[`SSD_D_IRQ]);
        end
    end

    a_irq_flag: assert property (
        apply && win[`SSD_D_IRQ] |=> decflag_q
    ) else $error("decoder flag not set on requesting match");

    for (genvar c = 0; c < `SSD_NCH; c++) begin : g_chflag
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                chflag_q[c] <= 1'b0;
            end else begin
                chflag_q[c] <= (chflag_q[c] && !(wr_flag && wdata_i[c]))
                    || (apply && trirq_q && cur_q == 4'(c)
                        && win_next != cur_q);
            end
        end
    end

    a_trans_flag: assert property (
        apply && trirq_q && win_next != cur_q |=> chflag_q[$past(cur_q)]
    ) else $error("leaving a state did not set its channel flag");

    // register read, data stand in the following cycle only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (!rd_i) begin
            rdata_q <= '0;
        end else begin
            unique case (addr_i)
                `SSD_CTRL_OFF: begin
                    rdata_q <= ssd_data_t'({run_q, cntmode_q, trirq_q, 2'b00});
                end
                `SSD_STATE_OFF: begin
                    rdata_q <= ssd_data_t'(cur_q);
                end
                `SSD_SENSOR_OFF: begin
                    rdata_q <= ssd_data_t'(sensor_q);
                end
                `SSD_SCAN_RESULT_REG_OFF: begin
                    rdata_q <= ssd_data_t'(scan_result_reg_q);
                end
                `SSD_DECEN_OFF: begin
                    rdata_q <= ssd_data_t'(decen_q);
                end
                `SSD_FLAG_OFF: begin
                    rdata_q <= ssd_data_t'({decflag_q, chflag_q});
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end

    a_state_read: assert property (
        rd_i && addr_i == `SSD_STATE_OFF |=> rdata_o == ssd_data_t'($past(cur_q))
    ) else $error("state register read wrong");

    assign rdata_o = rdata_q;
    assign evt_o = evt_q;
    assign scan_result_reg_evt_o = scan_result_reg_q;
endmodule // ssd_decoder

// ---- design/ssd_defs.svh ----
// register offsets, field positions and sizes of the sensor state decoder
// assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH
`define SSD_AW 8
`define SSD_DW 32
`define SSD_NSTATE 16
`define SSD_NCH 16
`define SSD_NSENS 4
`define SSD_NEVT 3
`define SSD_NDESC 32
`define SSD_CTRL_OFF 8'h00
`define SSD_STATE_OFF 8'h04
`define SSD_SENSOR_OFF 8'h08
`define SSD_SCAN_RESULT_REG_OFF 8'h0c
`define SSD_DECEN_OFF 8'h10
`define SSD_FLAG_OFF 8'h14
`define SSD_DESC_SEL_BIT 7
`define SSD_CTRL_START 0
`define SSD_CTRL_STOP 1
`define SSD_CTRL_TRIRQ 2
`define SSD_CTRL_CNTMODE 3
`define SSD_CTRL_RUN 4
`define SSD_FLAG_DEC 16
`define SSD_D_CMP 0
`define SSD_D_MASK 4
`define SSD_D_NEXT 8
`define SSD_D_ACT 12
`define SSD_D_IRQ 15
`define SSD_D_CHAIN 16
`define SSD_DESC_W 17
`define SSD_LAST_STATE 4'hf
`endif

// ---- design/ssd_desc_mem.sv ----
// descriptor store: one write port, one registered read port
// assumes a single clock shared with the decoder
`timescale 1ns/10ps
`include "ssd_defs.svh"
module ssd_desc_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire ssd_pkg::ssd_didx_t waddr_i,
    input wire ssd_pkg::ssd_desc_t wdata_i,
    input wire ssd_pkg::ssd_didx_t raddr_i,
    output ssd_pkg::ssd_desc_t rdata_o
);
    import ssd_pkg::*;

    ssd_desc_t mem_q [`SSD_NDESC];
    ssd_desc_t rdata_q;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[raddr_i];
        end
    end

    assign rdata_o = rdata_q;
endmodule // ssd_desc_mem

// ---- design/ssd_pkg.sv ----
// types shared by the sensor state decoder files
// assumes ssd_defs.svh is on the include path
package ssd_pkg;
`include "ssd_defs.svh"
    typedef logic [`SSD_AW-1:0] ssd_addr_t;
    typedef logic [`SSD_DW-1:0] ssd_data_t;
    typedef logic [`SSD_DESC_W-1:0] ssd_desc_t;
    typedef logic [4:0] ssd_didx_t;
    typedef enum logic [1:0] {SSD_IDLE, SSD_RDA, SSD_CHKA, SSD_CHKB} ssd_eval_t;
endpackage

// ---- tb/ssd_pulse_counter_model.sv ----
// pulse counter model on the far side of the decoder event outputs
// assumes count pulse, direction and channel event are levels on clk_i
`timescale 1ns/10ps
module ssd_pulse_counter_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cnt_pulse_i,
    input wire logic cnt_dir_i,
    input wire logic ch_evt_i,
    output logic [7:0] count_o,
    output logic [7:0] hits_o,
    output logic [7:0] dir_err_o
);
    logic dir_q;
    logic pulse_q;
    logic ch_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_q <= 1'b0;
            pulse_q <= 1'b0;
            ch_q <= 1'b0;
            count_o <= 8'h00;
            hits_o <= 8'h00;
            dir_err_o <= 8'h00;
        end else begin
            dir_q <= cnt_dir_i;
            pulse_q <= cnt_pulse_i;
            ch_q <= ch_evt_i;
            if (cnt_pulse_i && !pulse_q) begin
                count_o <= cnt_dir_i ? count_o + 8'h01 : count_o - 8'h01;
                if (cnt_dir_i != dir_q) begin
                    dir_err_o <= dir_err_o + 8'h01;
                end
            end
            if (ch_evt_i && !ch_q) begin
                hits_o <= hits_o + 8'h01;
            end
        end
    end
endmodule // ssd_pulse_counter_model

// ---- tb/testbench.sv ----
// self-checking bench for the sensor state decoder with a pulse counter model
// assumes ssd_defs.svh on the include path and the package compiled first
`timescale 1ns/10ps
`include "ssd_defs.svh"
module testbench;
    import ssd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ssd_addr_t addr_i = '0;
    ssd_data_t wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    ssd_data_t rdata_o;
    logic scan_valid_i = 1'b0;
    logic [3:0] scan_ch_i = 4'h0;
    logic scan_res_i = 1'b0;
    logic scan_done_i = 1'b0;
    logic [2:0] evt_o;
    logic [15:0] scan_result_reg_evt_o;
    logic [7:0] cnt;
    logic [7:0] hits;
    logic [7:0] derr;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #20 clk_i = ~clk_i;
    ssd_decoder i_ssd_decoder (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .scan_valid_i(scan_valid_i), .scan_ch_i(scan_ch_i), .scan_res_i(scan_res_i),
        .scan_done_i(scan_done_i), .evt_o(evt_o), .scan_result_reg_evt_o(scan_result_reg_evt_o));
    ssd_pulse_counter_model i_ssd_pulse_counter_model (.clk_i(clk_i), .rst_i(rst_i),
        .cnt_pulse_i(evt_o[0]), .cnt_dir_i(evt_o[1]), .ch_evt_i(scan_result_reg_evt_o[6]),
        .count_o(cnt), .hits_o(hits), .dir_err_o(derr));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            test_done();
        end
    end
    task automatic chk(input ssd_data_t got, input ssd_data_t exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input ssd_addr_t a, input ssd_data_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rchk(input ssd_addr_t a, input ssd_data_t exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask
    task automatic scan(input logic [3:0] ch, input logic res);
        @(posedge clk_i);
        scan_valid_i <= 1'b1;
        scan_ch_i <= ch;
        scan_res_i <= res;
        @(posedge clk_i);
        scan_valid_i <= 1'b0;
    endtask
    // end of scan, then room for evaluation and the count pulse
    task automatic finish_scan(input int waitc);
        @(posedge clk_i);
        scan_done_i <= 1'b1;
        @(posedge clk_i);
        scan_done_i <= 1'b0;
        repeat (waitc) @(posedge clk_i);
    endtask
    function automatic ssd_data_t dw(logic ch, logic irq, logic [2:0] act,
        logic [3:0] nx, logic [3:0] msk, logic [3:0] cmp);
        return {15'h0000, ch, irq, act, nx, msk, cmp};
    endfunction
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(`SSD_STATE_OFF, 32'h0);
        rchk(`SSD_CTRL_OFF, 32'h0);
        rchk(8'h80, 32'h0);
        rchk(8'h40, 32'h0);
        wr(`SSD_STATE_OFF, 32'hf);
        rchk(`SSD_STATE_OFF, 32'hf);
        $display("test reset done");
        wr(8'h80, dw(1'b0, 1'b1, 3'h3, 4'h3, 4'hc, 4'h3));
        wr(8'h84, dw(1'b0, 1'b0, 3'h0, 4'h5, 4'hc, 4'h3));
        wr(8'h98, dw(1'b0, 1'b0, 3'h1, 4'h0, 4'hc, 4'h0));
        wr(`SSD_DECEN_OFF, 32'h1040);
        wr(`SSD_STATE_OFF, 32'h0);
        wr(`SSD_CTRL_OFF, 32'hd);
        rchk(`SSD_CTRL_OFF, 32'h1c);
        scan(4'h6, 1'b1);
        scan(4'h3, 1'b1);
        scan(4'hc, 1'b1);
        rchk(`SSD_STATE_OFF, 32'h0);
        rchk(`SSD_SENSOR_OFF, 32'h3);
        finish_scan(8);
        rchk(`SSD_STATE_OFF, 32'h3);
        rchk(`SSD_FLAG_OFF, 32'h10001);
        chk({24'h000000, cnt}, 32'h1);
        chk({29'h00000000, evt_o}, 32'h2);
        chk({16'h0000, scan_result_reg_evt_o}, 32'h1048);
        chk({24'h000000, hits}, 32'h1);
        wr(`SSD_FLAG_OFF, 32'hffffffff);
        rchk(`SSD_FLAG_OFF, 32'h0);
        $display("test count up done");
        scan(4'h6, 1'b0);
        scan(4'hc, 1'b0);
        finish_scan(8);
        rchk(`SSD_STATE_OFF, 32'h0);
        rchk(`SSD_FLAG_OFF, 32'h8);
        rchk(`SSD_SENSOR_OFF, 32'hc);
        chk({24'h000000, cnt}, 32'h0);
        chk({29'h00000000, evt_o}, 32'h0);
        chk({24'h000000, derr}, 32'h0);
        $display("test count down done");
        wr(`SSD_CTRL_OFF, 32'he);
        rchk(`SSD_CTRL_OFF, 32'hc);
        scan(4'h6, 1'b1);
        scan(4'hc, 1'b1);
        finish_scan(8);
        rchk(`SSD_STATE_OFF, 32'h0);
        $display("test stopped done");
        wr(8'ha0, dw(1'b1, 1'b0, 3'h0, 4'h1, 4'h0, 4'h0));
        wr(8'ha4, dw(1'b0, 1'b0, 3'h0, 4'h2, 4'h0, 4'h0));
        wr(8'ha8, dw(1'b0, 1'b1, 3'h4, 4'h9, 4'hc, 4'h3));
        wr(8'hac, dw(1'b0, 1'b0, 3'h0, 4'h7, 4'h0, 4'hf));
        wr(`SSD_FLAG_OFF, 32'hffffffff);
        wr(`SSD_STATE_OFF, 32'h4);
        wr(`SSD_CTRL_OFF, 32'h1);
        finish_scan(12);
        rchk(`SSD_STATE_OFF, 32'h9);
        chk({29'h00000000, evt_o}, 32'h4);
        rchk(`SSD_FLAG_OFF, 32'h10000);
        $display("test chain done");
        test_done();
    end
endmodule // testbench
